// >>> verilog/aic_diag.sv
// diagnostic record of a four channel analog input module
module aic_diag import aic_pkg::*; #(
  parameter int DIV = TICK_DIV
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [NUM_CH-1:0] param_err,
  input wire logic [NUM_CH-1:0] wire_break,
  input wire logic [NUM_CH-1:0] int_lost,
  input wire logic [NUM_CH-1:0] under_range,
  input wire logic [NUM_CH-1:0] over_range,
  input wire logic rec_rd,
  input wire logic [IDX_W-1:0] rec_idx,
  output logic [7:0] rec_data,
  output logic rec_valid,
  output logic diag_incoming,
  output logic diag_going,
  output logic module_fault_indicator
);

  if (NUM_CH != 4) begin : g_bad_ch
    $error("aic_diag: record layout needs four channels");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] data;
    logic valid;
    logic [TICK_W-1:0] stamp;
    logic inc;
    logic go;
    logic fault;
  } aic_diag_t;

  aic_diag_t st;
  aic_diag_t next_st;

  logic [TICK_W-1:0] us_count;
  logic [NUM_CH-1:0][7:0] ch_err;
  logic [NUM_CH-1:0] ch_active;
  logic [NUM_CH-1:0] ch_inc;
  logic [NUM_CH-1:0] ch_go;
  logic [NUM_CH-1:0] ch_clr;
  logic [7:0] group_sum;
  logic [7:0] mod_diag;

  // ----------------------------------------
  // ticker
  // ----------------------------------------
  aic_ticker #(
    .DIV(DIV)
  ) u_ticker (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .us_count(us_count)
  );

  // ----------------------------------------
  // channels
  // ----------------------------------------
  for (genvar k = 0; k < NUM_CH; k++) begin : g_ch
    assign ch_clr[k] = rec_rd && rec_idx == IDX_CH0 + 5'(k);
    aic_channel u_ch (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .param_err(param_err[k]),
      .wire_break(wire_break[k]),
      .int_lost(int_lost[k]),
      .under_range(under_range[k]),
      .over_range(over_range[k]),
      .clr_lost(ch_clr[k]),
      .err_byte(ch_err[k]),
      .active(ch_active[k]),
      .incoming(ch_inc[k]),
      .going(ch_go[k])
    );
  end

  // ----------------------------------------
  // summaries
  // ----------------------------------------
  always_comb begin
    group_sum = BYTE_ZERO;
    for (int k = 0; k < NUM_CH; k++) begin
      group_sum[k] = chan_has_err(ch_err[k]);
    end
    mod_diag = BYTE_ZERO;
    mod_diag[BIT_MOD_CHAN] = |group_sum;
  end

  // ----------------------------------------
  // record read and event capture
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.valid = rec_rd;
    next_st.inc = |ch_inc;
    next_st.go = |ch_go;
    next_st.fault = |ch_active;
    if (|ch_inc) begin
      next_st.stamp = us_count;
    end
    if (rec_rd) begin
      case (rec_idx)
        IDX_MOD_DIAG: begin
          next_st.data = mod_diag;
        end
        IDX_CHAN_COUNT: begin
          next_st.data = CHAN_COUNT_VAL;
        end
        IDX_GROUP_SUM: begin
          next_st.data = group_sum;
        end
        5'h08, 5'h09, 5'h0A, 5'h0B: begin
          next_st.data = ch_err[2'(rec_idx - IDX_CH0)];
        end
        5'h0C, 5'h0D, 5'h0E, 5'h0F: begin
          next_st.data = BYTE_ZERO;
        end
        5'h10: begin
          next_st.data = st.stamp[31:24];
        end
        5'h11: begin
          next_st.data = st.stamp[23:16];
        end
        5'h12: begin
          next_st.data = st.stamp[15:8];
        end
        5'h13: begin
          next_st.data = st.stamp[7:0];
        end
        default: begin
          next_st.data = BYTE_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rec_data = st.data;
  assign rec_valid = st.valid;
  assign diag_incoming = st.inc;
  assign diag_going = st.go;
  assign module_fault_indicator = st.fault;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_read(logic [4:0] idx);
    rec_rd && rec_idx == idx;
  endsequence

  sequence s_ch0_idle_with(logic cause);
    !ch_active[0] && cause;
  endsequence

  chk_count_byte: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_read(IDX_CHAN_COUNT) |=> rec_valid && rec_data == CHAN_COUNT_VAL)
    else $error("channel count byte wrong");

  chk_group_summary: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_read(IDX_GROUP_SUM) |=> rec_data[7:4] == 4'h0
      && rec_data[0] == $past(|(ch_err[0] & DEFINED_MASK)))
    else $error("summary byte wrong");

  chk_summary_exact: assert property (@(posedge sys_clk) disable iff (!rst_n)
    group_sum[1] == (ch_err[1][BIT_PARAM] || ch_err[1][BIT_WIRE]
      || ch_err[1][BIT_LOST] || ch_err[1][BIT_UNDER] || ch_err[1][BIT_OVER]))
    else $error("summary bit does not follow channel byte");

  chk_reserved_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_read(IDX_CH0) |=> rec_data[3:1] == 3'h0)
    else $error("reserved channel bits set");

  chk_param_seen: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_ch0_idle_with(param_err[0]) |=> ch_err[0][BIT_PARAM] && ch_inc[0])
    else $error("parameter error not captured");

  chk_wire_seen: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_ch0_idle_with(wire_break[0]) |=> ch_err[0][BIT_WIRE])
    else $error("wire break not captured");

  chk_lost_seen: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_ch0_idle_with(int_lost[0]) ##1 !ch_active[0] |=> ch_err[0][BIT_LOST])
    else $error("lost interrupt not captured");

  chk_under_seen: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_ch0_idle_with(under_range[0]) |=> ch_err[0][BIT_UNDER])
    else $error("underflow not captured");

  chk_over_seen: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_ch0_idle_with(over_range[0]) |=> ch_err[0][BIT_OVER])
    else $error("overflow not captured");

  chk_unused_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rec_rd && rec_idx >= IDX_UNUSED0 && rec_idx <= IDX_UNUSED3 |=> rec_data == BYTE_ZERO)
    else $error("unused channel byte not zero");

  chk_stamp_catch: assert property (@(posedge sys_clk) disable iff (!rst_n)
    |ch_inc |=> st.stamp == $past(us_count))
    else $error("timestamp not caught");

  chk_stamp_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_read(IDX_STAMP3) && !(|ch_inc) |=> rec_data == $past(st.stamp[7:0]))
    else $error("timestamp low byte wrong");

  chk_mod_chan_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_read(IDX_MOD_DIAG) |=> rec_data[BIT_MOD_CHAN] == $past(|ch_active))
    else $error("module channel error bit wrong");

  chk_freeze_active: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ch_active[2] && $past(ch_active[2]) |-> $stable(ch_err[2]))
    else $error("event stored while diagnostic active");

  chk_going_event: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(ch_active[3]) |-> ch_go[3] ##1 (diag_going && !module_fault_indicator))
    else $error("outgoing event missing");

  chk_incoming_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(ch_active[1]) |-> ch_inc[1] ##1 diag_incoming && module_fault_indicator)
    else $error("incoming event missing");

endmodule : aic_diag

// >>> verilog/aic_pkg.sv
// constants of the analog input channel diagnostic record
// Behaviour
// - channel count byte always reads 04h
// - summary byte bits 0..3 flag error in channel group 0..3, bits 7..4 zero
// - channel byte bit 0 flags parameterization error, bits 3..1 zero
// - channel byte bit 4 flags a broken input wire
// - channel byte bit 5 flags a lost hardware interrupt of that channel
// - channel byte bit 6 flags signal below measuring range
// - channel byte bit 7 flags signal above measuring range
// - bytes for channels four to seven exist and always read zero
// - four timestamp bytes hold ticker value caught at the incoming diagnostic event
// - microsecond ticker starts at zero after reset, steps once per microsecond
// - ticker is 32 bits wide and wraps to zero, then keeps counting
// - module diagnostic byte bit 3 set while any channel error present
// - cause gone gives outgoing event; events meanwhile on channel are not stored
package aic_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_PERIOD_NS = 1000;
  localparam int TICK_DIV = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 32;

  // ----------------------------------------
  // record byte indices
  // ----------------------------------------
  localparam int IDX_W = 5;
  localparam logic [4:0] IDX_MOD_DIAG = 5'h00;
  localparam logic [4:0] IDX_CHAN_COUNT = 5'h06;
  localparam logic [4:0] IDX_GROUP_SUM = 5'h07;
  localparam logic [4:0] IDX_CH0 = 5'h08;
  localparam logic [4:0] IDX_UNUSED0 = 5'h0C;
  localparam logic [4:0] IDX_UNUSED3 = 5'h0F;
  localparam logic [4:0] IDX_STAMP0 = 5'h10;
  localparam logic [4:0] IDX_STAMP3 = 5'h13;

  // ----------------------------------------
  // field positions and values
  // ----------------------------------------
  localparam int NUM_CH = 4;
  localparam logic [7:0] CHAN_COUNT_VAL = 8'h04;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] DEFINED_MASK = 8'hF1;
  localparam int BIT_PARAM = 0;
  localparam int BIT_WIRE = 4;
  localparam int BIT_LOST = 5;
  localparam int BIT_UNDER = 6;
  localparam int BIT_OVER = 7;
  localparam int BIT_MOD_CHAN = 3;

  // assemble a channel error byte from its causes
  function automatic logic [7:0] chan_byte(input logic p, input logic w,
    input logic l, input logic u, input logic o);
    chan_byte = {o, u, l, w, 3'h0, p};
  endfunction : chan_byte

  // any defined error bit in a channel byte
  function automatic logic chan_has_err(input logic [7:0] b);
    chan_has_err = |(b & DEFINED_MASK);
  endfunction : chan_has_err

endpackage : aic_pkg

// >>> verilog/aic_ticker.sv
// free running microsecond ticker
module aic_ticker import aic_pkg::*; #(
  parameter int DIV = TICK_DIV
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  output logic [TICK_W-1:0] us_count
);

  if (DIV < 1 || DIV > 255) begin : g_bad_div
    $error("aic_ticker: DIV out of range");
  end

  typedef struct packed {
    logic [7:0] div;
    logic [TICK_W-1:0] us;
  } aic_tick_t;

  aic_tick_t st;
  aic_tick_t next_st;
  localparam logic [7:0] DIV_LAST = 8'(DIV - 1);

  // ----------------------------------------
  // divider and counter
  // ----------------------------------------
  always_comb begin
    next_st = st;
    if (st.div == DIV_LAST) begin
      next_st.div = 8'h00;
      next_st.us = st.us + 32'h1;
    end else begin
      next_st.div = st.div + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign us_count = st.us;

  chk_ticker_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st.div == DIV_LAST |=> st.us == $past(st.us) + 32'h1)
    else $error("ticker did not step");
  chk_ticker_wrap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st.div == DIV_LAST && &st.us |=> st.us == 32'h0)
    else $error("ticker did not wrap");

endmodule : aic_ticker

// >>> verilog/aic_channel.sv
// per-channel diagnostic tracker with incoming and outgoing events
module aic_channel import aic_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic param_err,
  input wire logic wire_break,
  input wire logic int_lost,
  input wire logic under_range,
  input wire logic over_range,
  input wire logic clr_lost,
  output logic [7:0] err_byte,
  output logic active,
  output logic incoming,
  output logic going
);

  typedef struct packed {
    logic lost;
    logic act;
    logic [7:0] snap;
    logic inc;
    logic go;
  } aic_chan_t;

  aic_chan_t st;
  aic_chan_t next_st;
  logic [7:0] live;

  // ----------------------------------------
  // capture and release
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.inc = 1'b0;
    next_st.go = 1'b0;
    next_st.lost = (st.lost & ~clr_lost) | int_lost;
    live = chan_byte(param_err, wire_break, st.lost, under_range, over_range);
    if (!st.act && chan_has_err(live)) begin
      next_st.act = 1'b1;
      next_st.snap = live;
      next_st.inc = 1'b1;
    end else if (st.act && !chan_has_err(live)) begin
      next_st.act = 1'b0;
      next_st.snap = BYTE_ZERO;
      next_st.go = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign err_byte = st.snap;
  assign active = st.act;
  assign incoming = st.inc;
  assign going = st.go;

endmodule : aic_channel

// >>> bench/aic_host.sv
// far-side record reader model
module aic_host import aic_pkg::*; (
  input wire logic sys_clk,
  input wire logic rec_valid,
  input wire logic [7:0] rec_data,
  output logic rec_rd,
  output logic [IDX_W-1:0] rec_idx
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    rec_rd = 1'b0;
    rec_idx = '0;
  end

  // one record byte read, answer awaited for a few cycles
  task automatic rd(input logic [IDX_W-1:0] idx, output logic [7:0] data, output bit ok);
    int i;
    ok = 1'b0;
    data = 'x;
    @(posedge sys_clk);
    rec_rd <= 1'b1;
    rec_idx <= idx;
    @(posedge sys_clk);
    rec_rd <= 1'b0;
    // released index shows a changed pattern
    rec_idx <= ~idx;
    for (i = 0; i < 4 && !ok; i++) begin
      @(posedge sys_clk);
      if (rec_valid === 1'b1) begin
        data = rec_data;
        ok = 1'b1;
      end
    end
  endtask : rd
endmodule : aic_host

// >>> bench/aic_tb.sv
// self-checking bench of the diagnostic record
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end

module tb import aic_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DV = 4;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [NUM_CH-1:0] param_err = '0;
  logic [NUM_CH-1:0] wire_break = '0;
  logic [NUM_CH-1:0] int_lost = '0;
  logic [NUM_CH-1:0] under_range = '0;
  logic [NUM_CH-1:0] over_range = '0;
  logic rec_rd;
  logic [IDX_W-1:0] rec_idx;
  logic [7:0] rec_data;
  logic rec_valid;
  logic diag_incoming;
  logic diag_going;
  logic module_fault_indicator;
  int fail_count = 0;
  int n_checks = 0;
  int n_in = 0;
  int n_go = 0;
  int m_div = 0;
  logic [31:0] m_us = '0;

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // event counters and ticker model
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (diag_incoming === 1'b1) n_in++;
    if (diag_going === 1'b1) n_go++;
    if (!rst_n) begin
      m_div <= 0;
      m_us <= '0;
    end else if (m_div == DV - 1) begin
      m_div <= 0;
      m_us <= m_us + 32'h1;
    end else begin
      m_div <= m_div + 1;
    end
  end

  aic_diag #(.DIV(DV)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .param_err(param_err),
    .wire_break(wire_break), .int_lost(int_lost), .under_range(under_range),
    .over_range(over_range), .rec_rd(rec_rd), .rec_idx(rec_idx), .rec_data(rec_data),
    .rec_valid(rec_valid), .diag_incoming(diag_incoming), .diag_going(diag_going),
    .module_fault_indicator(module_fault_indicator));

  aic_host host (.sys_clk(sys_clk), .rec_valid(rec_valid), .rec_data(rec_data),
    .rec_rd(rec_rd), .rec_idx(rec_idx));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic rchk(input logic [IDX_W-1:0] idx, input logic [7:0] e);
    logic [7:0] d;
    bit ok;
    host.rd(idx, d, ok);
    `CHK("rec_valid", 1'b1, ok)
    `CHK("rec_data", e, d)
  endtask : rchk

  task automatic settle;
    repeat (4) @(posedge sys_clk);
  endtask : settle

  task automatic set_cause(input int ch, input logic [7:0] b);
    param_err[ch] <= b[0];
    wire_break[ch] <= b[4];
    under_range[ch] <= b[6];
    over_range[ch] <= b[7];
  endtask : set_cause

  // one diagnostic raised and removed on a channel
  task automatic ev(input int ch, input logic [7:0] b);
    int i0;
    int g0;
    logic [31:0] ets;
    i0 = n_in;
    g0 = n_go;
    @(posedge sys_clk);
    while (m_div != DV - 1) @(posedge sys_clk);
    ets = m_us + 32'h1;
    set_cause(ch, b);
    settle;
    rchk(IDX_CH0 + 5'(ch), b);
    rchk(IDX_GROUP_SUM, 8'(1 << ch));
    rchk(IDX_MOD_DIAG, 8'h08);
    `CHK("module_fault_indicator", 1'b1, module_fault_indicator)
    `CHK("diag_incoming count", i0 + 1, n_in)
    rchk(IDX_STAMP0, ets[31:24]);
    rchk(IDX_STAMP0 + 5'h1, ets[23:16]);
    rchk(IDX_STAMP0 + 5'h2, ets[15:8]);
    rchk(IDX_STAMP3, ets[7:0]);
    @(posedge sys_clk);
    set_cause(ch, 8'h00);
    settle;
    rchk(IDX_CH0 + 5'(ch), 8'h00);
    rchk(IDX_GROUP_SUM, 8'h00);
    `CHK("diag_going count", g0 + 1, n_go)
    `CHK("module_fault_indicator", 1'b0, module_fault_indicator)
  endtask : ev

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    int i0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 32; i++) rchk(5'(i), (i == 6) ? 8'h04 : 8'h00);
    ev(0, 8'h01);
    ev(1, 8'h10);
    ev(2, 8'h40);
    ev(3, 8'h80);
    ev(0, 8'hD1);
    @(posedge sys_clk);
    int_lost[1:0] <= 2'b11;
    @(posedge sys_clk);
    int_lost[1:0] <= 2'b00;
    settle;
    rchk(IDX_CH0 + 5'h1, 8'h20);
    rchk(IDX_CH0, 8'h20);
    settle;
    rchk(IDX_CH0 + 5'h1, 8'h00);
    rchk(IDX_CH0, 8'h00);
    `CHK("module_fault_indicator", 1'b0, module_fault_indicator)
    i0 = n_in;
    @(posedge sys_clk);
    wire_break[0] <= 1'b1;
    settle;
    @(posedge sys_clk);
    over_range[0] <= 1'b1;
    settle;
    rchk(IDX_CH0, 8'h10);
    @(posedge sys_clk);
    wire_break[0] <= 1'b0;
    settle;
    rchk(IDX_CH0, 8'h10);
    @(posedge sys_clk);
    over_range[0] <= 1'b0;
    settle;
    rchk(IDX_CH0, 8'h00);
    `CHK("diag_incoming count", i0 + 1, n_in)
    @(posedge sys_clk);
    wire_break[3] <= 1'b1;
    settle;
    @(posedge sys_clk);
    rst_n <= 1'b0;
    wire_break[3] <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    rchk(IDX_CH0 + 5'h3, 8'h00);
    rchk(IDX_STAMP3, 8'h00);
    `CHK("module_fault_indicator", 1'b0, module_fault_indicator)
    report_and_stop;
  end

  initial begin
    #200000;
    fail_count++;
    report_and_stop;
  end
endmodule : tb
